// >>> pop_pkg.sv
// package: constants and types of the pcie option logic
package pop_pkg;
   // timeout, status counter and credit counter widths
   localparam int unsigned TMR_W = 15;
   localparam int unsigned CNT_W = 16;
   localparam int unsigned CRD_W = 4;
   // message codes of the pcie protocol
   localparam logic [7:0] MSG_UNLOCK   = 8'h00;
   localparam logic [7:0] MSG_ATS_INV  = 8'h01;
   localparam logic [7:0] MSG_ATS_PRG  = 8'h05;
   localparam logic [7:0] MSG_PM_PME   = 8'h18;
   localparam logic [7:0] MSG_TURN_OFF = 8'h19;
   localparam logic [7:0] MSG_TO_ACK   = 8'h1B;
   localparam logic [7:0] MSG_INT_LO   = 8'h20;
   localparam logic [7:0] MSG_INT_HI   = 8'h27;
   localparam logic [7:0] MSG_ERR_COR  = 8'h30;
   localparam logic [7:0] MSG_ERR_NF   = 8'h31;
   localparam logic [7:0] MSG_ERR_FAT  = 8'h33;
   // pad symbol sent as link number when not downstream facing
   localparam logic [7:0] LINK_PAD = 8'hF7;
   // apb register byte offsets
   localparam logic [7:0] ADDR_OPTIONS = 8'h00;
   localparam logic [7:0] ADDR_TIMERS  = 8'h04;
   localparam logic [7:0] ADDR_FWD     = 8'h08;
   localparam logic [7:0] ADDR_UR      = 8'h0C;
   localparam logic [7:0] ADDR_DROP    = 8'h10;
   localparam logic [7:0] ADDR_CLEAR   = 8'h14;
   localparam logic [7:0] ADDR_STATUS  = 8'h18;
   // field positions
   localparam int unsigned OPT_LINK_LSB = 16;
   localparam int unsigned TMR_RPL_LSB  = 16;
   localparam int unsigned STAT_FLG_LSB = 8;
   localparam int unsigned CLR_FWD      = 0;
   localparam int unsigned CLR_UR       = 1;
   localparam int unsigned CLR_DROP     = 2;
   // reset values
   localparam logic [31:0]      RST_RDATA = 32'h0000_0000;
   localparam logic [CNT_W-1:0] RST_CNT   = 16'h0000;
   localparam logic [CRD_W-1:0] RST_CRD   = 4'h0;

   typedef enum logic [1:0] {
      KIND_POSTED = 2'b00,
      KIND_NP     = 2'b01,
      KIND_CPL    = 2'b10,
      KIND_MSG    = 2'b11
   } pop_kind_e;

   typedef enum logic [1:0] {
      FUNC_ABS = 2'b00,
      FUNC_ADD = 2'b01,
      FUNC_SUB = 2'b10
   } pop_func_e;
endpackage

// >>> pop_timer_if.sv
// interface: one timer table value, its override and the result
interface pop_timer_if;
   import pop_pkg::*;
   logic [TMR_W-1:0] base;
   logic [TMR_W-1:0] ovr;
   pop_func_e        func;
   logic             enable;
   logic [TMR_W-1:0] result;
   modport calc (input base, input ovr, input func, input enable, output result);
   modport user (output base, output ovr, output func, output enable, input result);
endinterface

// >>> pop_timer_calc.sv
// module: applies an override function to a built-in timer value
module pop_timer_calc
   import pop_pkg::*;
(
   input  logic      pclk,
   input  logic      presetn,
   pop_timer_if.calc tmr
);
   typedef struct packed {
      logic [TMR_W-1:0] result;
   } pop_calc_s;

   pop_calc_s st_q;
   pop_calc_s st_d;

   // select absolute, add or subtract; sums wrap at the timer width
   always_comb begin
      st_d = st_q;
      if (!tmr.enable) begin
         st_d.result = tmr.base;
      end else begin
         case (tmr.func)
            FUNC_ABS: st_d.result = tmr.ovr;
            FUNC_ADD: st_d.result = tmr.base + tmr.ovr;
            FUNC_SUB: st_d.result = tmr.base - tmr.ovr;
            default:  st_d.result = tmr.base;
         endcase
      end
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign tmr.result = st_q.result;

   chk_calc_bypass: assert property (@(posedge pclk) disable iff (!presetn)
      presetn && !tmr.enable |=> tmr.result == $past(tmr.base))
      else $error("timer value does not follow table when override is off");
   chk_calc_func: assert property (@(posedge pclk) disable iff (!presetn)
      (presetn && tmr.enable && tmr.func == FUNC_SUB)
      |=> tmr.result == TMR_W'($past(tmr.base) - $past(tmr.ovr)))
      else $error("subtract override gives wrong timer value");
endmodule

// >>> pop_options_top.sv
// module: build-time tl, dl and pl options with receive routing and apb status
// Overview of operation
// - Routing option forwards routable received messages to the user stream, else they are dropped, except ATS Invalidate and PRG Response.
// - Endpoint routes Unlock and PME_Turn_Off messages.
// - Root port routes error messages plus PM_PME and PME_TO_ACK.
// - Root port also routes assert and deassert INTA to INTD messages.
// - Each pull request lets one non-posted TLP reach the user, unless NP_CRD_MAX credits are already held.
// - Pipeline option adds write-path stage only, or read and write stages.
// - Invalidate-reject option turns ATS Invalidate into unsupported request, else passes.
// - Group-response reject option turns ATS PRG Response into unsupported request.
// - ACK latency override combines with table value: absolute, add or subtract.
// - Replay timer override combines with table value: absolute, add or subtract.
// - Table values depend on negotiated link width and programmed payload size.
// - Lane reversal option enables reversed lane ordering support.
// - No-scrambling option bypasses the data scramblers, for diagnostics only.
// - Upconfigure cleared advertises not upconfigure capable during training.
// - Transmit L0s disable keeps the transmitter out of L0s.
// - Only downstream facing ports place the link number in TS1 and TS2.
module pop_options_top
   import pop_pkg::*;
#(
   parameter int unsigned      DATA_W       = 32,
   parameter int unsigned      NP_CRD_MAX   = 15,
   parameter bit               ROUTE_MSG    = 1'b0,
   parameter bit               ROOT_PORT    = 1'b0,
   parameter bit               NP_PULL      = 1'b0,
   parameter bit               PIPE_RW      = 1'b0,
   parameter bit               REJECT_INV   = 1'b0,
   parameter bit               REJECT_PRG   = 1'b0,
   parameter bit               ACK_OVR_EN   = 1'b0,
   parameter pop_func_e        ACK_OVR_FUNC = FUNC_ABS,
   parameter logic [TMR_W-1:0] ACK_OVR_VAL  = 15'h0000,
   parameter bit               RPL_OVR_EN   = 1'b0,
   parameter pop_func_e        RPL_OVR_FUNC = FUNC_ABS,
   parameter logic [TMR_W-1:0] RPL_OVR_VAL  = 15'h0000,
   parameter logic [TMR_W-1:0] ACK_UNIT     = 15'h0040,
   parameter logic [TMR_W-1:0] ACK_DELAY    = 15'h0010,
   parameter logic [TMR_W-1:0] RPL_UNIT     = 15'h00C0,
   parameter logic [TMR_W-1:0] RPL_DELAY    = 15'h0030,
   parameter bit               LANE_REV_EN  = 1'b0,
   parameter bit               NO_SCRAMBLE  = 1'b0,
   parameter bit               UPCFG_CAP    = 1'b1,
   parameter bit               L0S_DISABLE  = 1'b0,
   parameter bit               DOWNSTREAM   = 1'b0,
   parameter logic [7:0]       LINK_NUMBER  = 8'h00
)(
   input  logic              pclk,
   input  logic              presetn,
   input  logic [7:0]        paddr,
   input  logic              psel,
   input  logic              penable,
   input  logic              pwrite,
   input  logic [31:0]       pwdata,
   output logic [31:0]       prdata,
   output logic              pready,
   output logic              pslverr,
   input  logic              in_valid,
   input  pop_kind_e         in_kind,
   input  logic [7:0]        in_msg_code,
   input  logic [DATA_W-1:0] in_data,
   output logic              in_ready,
   output logic              rx_valid,
   output pop_kind_e         rx_kind,
   output logic [7:0]        rx_msg_code,
   output logic [DATA_W-1:0] rx_data,
   input  logic              rx_ready,
   input  logic              nonposted_pull_request,
   input  logic              nonposted_accept_ready,
   output logic              ur_report,
   input  logic [1:0]        link_width_code,
   input  logic [2:0]        mps_code,
   output logic [TMR_W-1:0]  ack_latency_limit,
   output logic [TMR_W-1:0]  replay_timeout_limit,
   output logic              lane_reversal_en,
   output logic              scramble_bypass,
   output logic              upcfg_advertise,
   input  logic              tx_l0s_request,
   output logic              tx_l0s_enter,
   output logic [7:0]        ts_link_number
);
   // refuse settings the logic cannot serve
   if (DATA_W < 1 || DATA_W > 32) begin : g_bad_width
      $error("DATA_W must be 1 to 32");
   end
   if (NP_CRD_MAX < 1 || NP_CRD_MAX > 15) begin : g_bad_crd
      $error("NP_CRD_MAX must be 1 to 15");
   end

   typedef struct packed {
      pop_kind_e         kind;
      logic [7:0]        code;
      logic [DATA_W-1:0] data;
   } pop_beat_s;

   typedef struct packed {
      logic             wr_full;
      pop_beat_s        wr;
      logic             rd_full;
      pop_beat_s        rd;
      logic             out_valid;
      pop_beat_s        out;
      logic             in_ready;
      logic             ur;
      logic [CRD_W-1:0] crd;
      logic [CNT_W-1:0] fwd_cnt;
      logic [CNT_W-1:0] ur_cnt;
      logic [CNT_W-1:0] drop_cnt;
      logic             lane_rev;
      logic             scr_byp;
      logic             upcfg;
      logic             l0s;
      logic [7:0]       link_num;
      logic [31:0]      prdata;
      logic             pready;
      logic             pslverr;
   } pop_state_s;

   localparam logic [CRD_W-1:0] CRD_MAX = CRD_W'(NP_CRD_MAX);
   localparam logic [7:0] LINK_TS = DOWNSTREAM ? LINK_NUMBER : LINK_PAD;

   pop_state_s st_q;
   pop_state_s st_d;
   pop_timer_if tmr_ack ();
   pop_timer_if tmr_rpl ();

   // classification of the incoming word
   logic in_take;
   logic is_msg;
   logic is_inv;
   logic is_prg;
   logic ep_route;
   logic rp_err;
   logic rp_int;
   logic routable;
   logic reject;
   logic drop;
   // pipeline movement and apb decode
   logic np_permit;
   logic wr_move;
   logic setup;
   logic acc;
   logic known;
   logic [31:0] rd_mux;
   logic [31:0] opts;

   assign in_take  = in_valid && st_q.in_ready;
   assign is_msg   = (in_kind == KIND_MSG);
   assign is_inv   = is_msg && (in_msg_code == MSG_ATS_INV);
   assign is_prg   = is_msg && (in_msg_code == MSG_ATS_PRG);
   assign ep_route = (in_msg_code == MSG_UNLOCK) || (in_msg_code == MSG_TURN_OFF);
   assign rp_err   = (in_msg_code == MSG_ERR_COR) || (in_msg_code == MSG_ERR_NF)
                   || (in_msg_code == MSG_ERR_FAT) || (in_msg_code == MSG_PM_PME)
                   || (in_msg_code == MSG_TO_ACK);
   assign rp_int   = (in_msg_code >= MSG_INT_LO) && (in_msg_code <= MSG_INT_HI);
   assign routable = ROUTE_MSG && (ROOT_PORT ? (rp_err || rp_int) : ep_route);
   // ats messages reject as unsupported, else pass through
   assign reject   = (is_inv && REJECT_INV) || (is_prg && REJECT_PRG);
   assign drop     = is_msg && !is_inv && !is_prg && !routable;

   // only the chosen flow control input is looked at
   assign np_permit = NP_PULL ? (st_q.crd != RST_CRD) : nonposted_accept_ready;

   // built-in table: payload scales up, link width scales down
   assign tmr_ack.base   = ((ACK_UNIT << mps_code) >> link_width_code) + ACK_DELAY;
   assign tmr_ack.ovr    = ACK_OVR_VAL;
   assign tmr_ack.func   = ACK_OVR_FUNC;
   assign tmr_ack.enable = ACK_OVR_EN;
   assign tmr_rpl.base   = ((RPL_UNIT << mps_code) >> link_width_code) + RPL_DELAY;
   assign tmr_rpl.ovr    = RPL_OVR_VAL;
   assign tmr_rpl.func   = RPL_OVR_FUNC;
   assign tmr_rpl.enable = RPL_OVR_EN;

   // timer calculators, one per timer
   pop_timer_calc u_ack (
      .pclk    (pclk),
      .presetn (presetn),
      .tmr     (tmr_ack.calc)
   );
   pop_timer_calc u_rpl (
      .pclk    (pclk),
      .presetn (presetn),
      .tmr     (tmr_rpl.calc)
   );

   // apb phases and read mux
   assign setup = psel && !penable;
   assign acc   = psel && penable && st_q.pready;
   assign opts  = {8'h00, LINK_TS, 3'b000, DOWNSTREAM, L0S_DISABLE, UPCFG_CAP,
                   NO_SCRAMBLE, LANE_REV_EN, RPL_OVR_EN, ACK_OVR_EN, REJECT_PRG,
                   REJECT_INV, PIPE_RW, NP_PULL, ROOT_PORT, ROUTE_MSG};
   always_comb begin
      known  = 1'b1;
      rd_mux = RST_RDATA;
      case (paddr)
         ADDR_OPTIONS: rd_mux = opts;
         ADDR_TIMERS: begin
            rd_mux[TMR_W-1:0] = tmr_ack.result;
            rd_mux[TMR_RPL_LSB +: TMR_W] = tmr_rpl.result;
         end
         ADDR_FWD:   rd_mux[CNT_W-1:0] = st_q.fwd_cnt;
         ADDR_UR:    rd_mux[CNT_W-1:0] = st_q.ur_cnt;
         ADDR_DROP:  rd_mux[CNT_W-1:0] = st_q.drop_cnt;
         ADDR_CLEAR: rd_mux = RST_RDATA;
         ADDR_STATUS: begin
            rd_mux[CRD_W-1:0] = st_q.crd;
            rd_mux[STAT_FLG_LSB +: 3] = {st_q.out_valid, st_q.rd_full, st_q.wr_full};
         end
         default: known = 1'b0;
      endcase
   end

   // next state: drain, advance the pipeline, accept, count, answer apb
   always_comb begin
      st_d = st_q;
      wr_move = 1'b0;
      st_d.ur = 1'b0;
      // user side handshake
      if (st_q.out_valid && rx_ready) begin
         st_d.out_valid = 1'b0;
      end
      // read path stage feeds the output
      if (PIPE_RW && st_d.rd_full && !st_d.out_valid) begin
         st_d.out       = st_d.rd;
         st_d.out_valid = 1'b1;
         st_d.rd_full   = 1'b0;
      end
      // write path stage leaves, non-posted only when permitted
      if (st_q.wr_full && (st_q.wr.kind != KIND_NP || np_permit)) begin
         if (PIPE_RW && !st_d.rd_full) begin
            st_d.rd      = st_q.wr;
            st_d.rd_full = 1'b1;
            wr_move      = 1'b1;
         end else if (!PIPE_RW && !st_d.out_valid) begin
            st_d.out       = st_q.wr;
            st_d.out_valid = 1'b1;
            wr_move        = 1'b1;
         end
      end
      if (wr_move) begin
         st_d.wr_full = 1'b0;
      end
      // pull credits: one per request cycle, one spent per leaving non-posted tlp
      if (NP_PULL) begin
         if (nonposted_pull_request && st_q.crd != CRD_MAX) begin
            st_d.crd = st_d.crd + 4'h1;
         end
         if (wr_move && st_q.wr.kind == KIND_NP) begin
            st_d.crd = st_d.crd - 4'h1;
         end
      end
      // counter clear by software; an event in the same cycle still counts
      if (acc && pwrite && paddr == ADDR_CLEAR) begin
         if (pwdata[CLR_FWD]) st_d.fwd_cnt = RST_CNT;
         if (pwdata[CLR_UR]) st_d.ur_cnt = RST_CNT;
         if (pwdata[CLR_DROP]) st_d.drop_cnt = RST_CNT;
      end
      if (st_q.out_valid && rx_ready) begin
         st_d.fwd_cnt = st_d.fwd_cnt + 16'h0001;
      end
      // accept a word: reject, drop or load the write stage
      if (in_take) begin
         if (reject) begin
            st_d.ur     = 1'b1;
            st_d.ur_cnt = st_d.ur_cnt + 16'h0001;
         end else if (drop) begin
            st_d.drop_cnt = st_d.drop_cnt + 16'h0001;
         end else begin
            st_d.wr      = '{kind: in_kind, code: in_msg_code, data: in_data};
            st_d.wr_full = 1'b1;
         end
      end
      st_d.in_ready = !st_d.wr_full;
      // physical layer options held from reset; l0s entry follows the request each cycle
      st_d.lane_rev = LANE_REV_EN;
      st_d.scr_byp  = NO_SCRAMBLE;
      st_d.upcfg    = UPCFG_CAP;
      st_d.link_num = LINK_TS;
      st_d.l0s      = tx_l0s_request && !L0S_DISABLE;
      // zero-wait apb: answer prepared in the setup cycle
      st_d.pready  = setup;
      st_d.pslverr = setup && !known;
      st_d.prdata  = (setup && !pwrite) ? rd_mux : RST_RDATA;
   end

   // state register; options load their build-time values at reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q          <= '0;
         st_q.in_ready <= 1'b1;
         st_q.lane_rev <= LANE_REV_EN;
         st_q.scr_byp  <= NO_SCRAMBLE;
         st_q.upcfg    <= UPCFG_CAP;
         st_q.link_num <= LINK_TS;
      end else begin
         st_q <= st_d;
      end
   end

   // outputs straight from the state register; timer limits from the calculator registers
   assign prdata               = st_q.prdata;
   assign pready               = st_q.pready;
   assign pslverr              = st_q.pslverr;
   assign in_ready             = st_q.in_ready;
   assign rx_valid             = st_q.out_valid;
   assign rx_kind              = st_q.out.kind;
   assign rx_msg_code          = st_q.out.code;
   assign rx_data              = st_q.out.data;
   assign ur_report            = st_q.ur;
   assign ack_latency_limit    = tmr_ack.result;
   assign replay_timeout_limit = tmr_rpl.result;
   assign lane_reversal_en     = st_q.lane_rev;
   assign scramble_bypass      = st_q.scr_byp;
   assign upcfg_advertise      = st_q.upcfg;
   assign tx_l0s_enter         = st_q.l0s;
   assign ts_link_number       = st_q.link_num;

   // checks
   sequence s_accept_msg;
      in_take && is_msg;
   endsequence

   chk_route_gate: assert property (@(posedge pclk) disable iff (!presetn)
      (rx_valid && rx_kind == KIND_MSG && rx_msg_code != MSG_ATS_INV
       && rx_msg_code != MSG_ATS_PRG) |-> ROUTE_MSG)
      else $error("message reached user with routing off");
   chk_ep_msgs: assert property (@(posedge pclk) disable iff (!presetn)
      (s_accept_msg and ##0 (ROUTE_MSG && !ROOT_PORT && ep_route))
      |=> st_q.wr_full && st_q.wr.code == $past(in_msg_code))
      else $error("endpoint routable message not loaded");
   chk_rp_err: assert property (@(posedge pclk) disable iff (!presetn)
      (s_accept_msg and ##0 (ROUTE_MSG && ROOT_PORT && rp_err))
      |=> st_q.wr_full ##0 $stable(st_q.drop_cnt))
      else $error("root port error or pm message not routed");
   chk_rp_int: assert property (@(posedge pclk) disable iff (!presetn)
      (s_accept_msg and ##0 (ROUTE_MSG && ROOT_PORT && rp_int)) |=> st_q.wr_full)
      else $error("root port interrupt message not routed");
   chk_np_pull: assert property (@(posedge pclk) disable iff (!presetn)
      (NP_PULL && st_q.wr_full && st_q.wr.kind == KIND_NP && st_q.crd == RST_CRD)
      |=> st_q.wr_full)
      else $error("non-posted tlp left without a pull request");
   chk_pipe_depth: assert property (@(posedge pclk) disable iff (!presetn)
      (PIPE_RW && wr_move) |=> st_q.rd_full && !st_q.wr_full)
      else $error("read path stage skipped");
   chk_reject_inv: assert property (@(posedge pclk) disable iff (!presetn)
      (in_take && is_inv) |=> (ur_report == REJECT_INV) && (st_q.wr_full != REJECT_INV))
      else $error("ats invalidate handled against option");
   chk_reject_prg: assert property (@(posedge pclk) disable iff (!presetn)
      (in_take && is_prg) |=> (ur_report == REJECT_PRG) && (st_q.wr_full != REJECT_PRG))
      else $error("ats group response handled against option");
   chk_pl_static: assert property (@(posedge pclk)
      disable iff (!presetn)
      lane_reversal_en == LANE_REV_EN && scramble_bypass == NO_SCRAMBLE
      && upcfg_advertise == UPCFG_CAP && ts_link_number == LINK_TS)
      else $error("physical layer option differs from build value");
   chk_l0s_block: assert property (@(posedge pclk) disable iff (!presetn)
      tx_l0s_request |=> tx_l0s_enter == !L0S_DISABLE)
      else $error("transmit l0s entry against option");
   chk_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
      setup |=> pready ##1 !pready)
      else $error("apb answer not one cycle after setup");
endmodule

// >>> pop_user_model.sv
// partner: user receive logic with random stalls and non-posted pull requests
module pop_user_model
   import pop_pkg::*;
(
   input  logic pclk,
   input  logic presetn,
   input  logic rx_valid,
   input  logic pull_go,
   output logic rx_ready,
   output logic nonposted_pull_request,
   output logic nonposted_accept_ready
);
   timeunit 1ns;
   timeprecision 1ps;

   // pull mode only: accept-ready is never raised beside pull requests
   initial begin
      rx_ready = 1'b0;
      nonposted_pull_request = 1'b0;
      nonposted_accept_ready = 1'b0;
   end

   // random stalls, but every offered word is taken within a few cycles
   always @(posedge pclk) begin
      rx_ready <= presetn && ($urandom_range(3) != 0);
      nonposted_pull_request <= pull_go; // one cycle high per request
   end
endmodule

// >>> tb_pcie_tl_dl_pl_option_logic.sv
// testbench: receive routing, non-posted pull, timers, static options and apb status
module tb_pcie_tl_dl_pl_option_logic
   import pop_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // override values keep both timeouts inside the counter width
   localparam logic [14:0] OV_A = 15'h0100;
   localparam logic [14:0] OV_R = 15'h0020;
   // build options in option-word order, bit 0 first, and the advertised link number
   localparam logic [12:0] OPT     = 13'h1BD5;
   localparam logic [7:0]  LINK_NO = 8'h2A;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00, in_msg_code = 8'h00, rx_msg_code, ts_link_number;
   logic [31:0] pwdata = 32'h0, prdata, in_data = 32'h0, rx_data, rd;
   logic        pready, pslverr, in_valid = 1'b0, in_ready, rx_valid, rx_ready, ur_report;
   logic        nonposted_pull_request, nonposted_accept_ready, pull_go = 1'b0, er;
   logic        lane_reversal_en, scramble_bypass, upcfg_advertise, tx_l0s_enter;
   logic        tx_l0s_request = 1'b0;
   logic [1:0]  link_width_code = 2'h0;
   logic [2:0]  mps_code = 3'h0;
   logic [14:0] ack_latency_limit, replay_timeout_limit, eb;
   pop_kind_e   in_kind = KIND_POSTED, rx_kind;
   logic [41:0] exp_q[$];
   int          err_count = 0, n_compared = 0, n_ur = 0;

   pop_options_top #(.ROUTE_MSG(OPT[0]), .ROOT_PORT(OPT[1]), .NP_PULL(OPT[2]), .PIPE_RW(OPT[3]),
      .REJECT_INV(OPT[4]), .REJECT_PRG(OPT[5]), .ACK_OVR_EN(OPT[6]), .ACK_OVR_FUNC(FUNC_ADD),
      .ACK_OVR_VAL(OV_A), .RPL_OVR_EN(OPT[7]), .RPL_OVR_FUNC(FUNC_SUB), .RPL_OVR_VAL(OV_R),
      .LANE_REV_EN(OPT[8]), .NO_SCRAMBLE(OPT[9]), .UPCFG_CAP(OPT[10]), .L0S_DISABLE(OPT[11]),
      .DOWNSTREAM(OPT[12]), .LINK_NUMBER(LINK_NO)) uut (.*);
   pop_user_model u_model (.*);

   always #20 pclk = ~pclk;

   task automatic check(input logic [41:0] got, input logic [41:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic close_out;
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // offers one word, notes it when it should reach the user, keeps two-cycle spacing
   task automatic send(input pop_kind_e k, input logic [7:0] c, input logic fwd);
      logic [31:0] d;
      d = $urandom;
      if (fwd) exp_q.push_back({k, c, d});
      in_valid <= 1'b1;
      in_kind <= k;
      in_msg_code <= c;
      in_data <= d;
      do @(posedge pclk); while (in_ready !== 1'b1);
      in_valid <= 1'b0;
      @(posedge pclk);
   endtask

   // one apb transfer: setup, access held until pready, then release
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // scoreboard: each user handshake retires the oldest note; rejects are counted
   always @(posedge pclk) begin
      if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
         check({rx_kind, rx_msg_code, rx_data},
               exp_q.size() > 0 ? exp_q.pop_front() : {42{1'bx}});
      end
      if (ur_report === 1'b1) n_ur++;
   end

   // watchdog: the sequence needs well under a thousand cycles
   initial begin
      #800000;
      err_count++;
      close_out();
   end

   initial begin
      void'($urandom(66));
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      // timer table for every width with a random payload code
      for (int w = 0; w < 4; w++) begin
         link_width_code <= 2'(w);
         mps_code <= 3'($urandom_range(5));
         tx_l0s_request <= 1'b1;
         repeat (3) @(posedge pclk);
         eb = ((15'h0040 << mps_code) >> w) + 15'h0010;
         check(42'(ack_latency_limit), 42'(eb + OV_A));
         eb = ((15'h00C0 << mps_code) >> w) + 15'h0030;
         check(42'(replay_timeout_limit), 42'(eb - OV_R));
         check(42'(tx_l0s_enter), 42'h0);
      end
      check({lane_reversal_en, scramble_bypass, upcfg_advertise},
            42'({OPT[8], OPT[9], OPT[10]}));
      check(42'(ts_link_number), 42'(LINK_NO));
      // routing: endpoint messages pass, root port ones drop, invalidate rejected, prg passes
      send(KIND_POSTED, 8'h00, 1'b1);
      send(KIND_MSG, MSG_UNLOCK, 1'b1);
      send(KIND_MSG, MSG_TURN_OFF, 1'b1);
      send(KIND_MSG, MSG_ERR_COR, 1'b0);
      send(KIND_MSG, MSG_INT_LO, 1'b0);
      send(KIND_MSG, MSG_ATS_INV, 1'b0);
      send(KIND_MSG, MSG_ATS_PRG, 1'b1);
      // each non-posted word waits for exactly one pull request
      for (int i = 0; i < 2; i++) begin
         while (exp_q.size() > 0) @(posedge pclk);
         send(KIND_NP, 8'h00, 1'b1);
         repeat (8) @(posedge pclk);
         check(42'(rx_valid), 42'h0);
         pull_go <= 1'b1;
         @(posedge pclk);
         pull_go <= 1'b0;
      end
      while (exp_q.size() > 0) @(posedge pclk);
      repeat (4) @(posedge pclk);
      // status counters, option word, clearing and an unmapped offset
      apb(1'b0, ADDR_UR, 32'h0);
      check(42'(rd), 42'(n_ur));
      check(42'(n_ur), 42'h1);
      apb(1'b0, ADDR_FWD, 32'h0);
      check(42'(rd), 42'h6);
      apb(1'b0, ADDR_DROP, 32'h0);
      check(42'(rd), 42'h2);
      apb(1'b0, ADDR_OPTIONS, 32'h0);
      check(42'(rd), 42'({8'h00, LINK_NO, 3'b000, OPT}));
      apb(1'b1, ADDR_CLEAR, 32'h7);
      apb(1'b0, ADDR_FWD, 32'h0);
      check(42'(rd), 42'h0);
      apb(1'b0, 8'h40, 32'h0);
      check({er, rd}, 42'h1_0000_0000);
      close_out();
   end
endmodule
